// File: inc/asac_pkg.sv
// constants, field layouts and types of the axis sync action block
package asac_pkg;
  localparam int SET_N = 4;
  localparam int PIO_N = 8;
  localparam int SCFG_W = 13;
  // register byte offsets
  localparam logic [7:0] A_LPOS  = 8'h00;
  localparam logic [7:0] A_RPOS  = 8'h04;
  localparam logic [7:0] A_LRING = 8'h08;
  localparam logic [7:0] A_RRING = 8'h0c;
  localparam logic [7:0] A_SLP   = 8'h10;
  localparam logic [7:0] A_SLM   = 8'h14;
  localparam logic [7:0] A_SPLEN = 8'h18;
  localparam logic [7:0] A_SPCNT = 8'h1c;
  localparam logic [7:0] A_CMD   = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  localparam logic [7:0] A_MASK  = 8'h28;
  localparam logic [7:0] A_LIMEN = 8'h2c;
  localparam logic [7:0] A_MR0   = 8'h30;
  localparam logic [7:0] A_SC0   = 8'h40;
  // reset values and ranges
  localparam logic [31:0] RING_RST = 32'hffff_ffff;
  localparam logic [31:0] SLP_RST  = 32'h7fff_ffff;
  localparam logic [31:0] SL_BAD   = 32'h8000_0000;
  localparam logic [31:0] SL_MIN   = 32'h8000_0001;
  localparam logic [15:0] SPL_MIN  = 16'h0002;
  localparam logic [15:0] SPW_MIN  = 16'h0001;
  localparam logic [15:0] SPW_MAX  = 16'hfffe;
  localparam logic [15:0] SPN_MIN  = 16'h0001;
  // field positions
  localparam int CMD_SP_GO   = 0;
  localparam int CMD_SP_STOP = 1;
  localparam int CMD_ACT_LSB = 4;
  localparam int SPCNT_INF   = 16;
  localparam int ST_W        = 6;
  typedef enum logic [3:0] {
    SRC_NONE, SRC_CMP, SRC_DRV_GO, SRC_DRV_END, SRC_CV_IN, SRC_CV_OUT,
    SRC_SP_GO, SRC_SP_END, SRC_SP_PULSE, SRC_TMR_UP, SRC_PIO_RISE,
    SRC_PIO_FALL, SRC_RISE_LO, SRC_RISE_HI, SRC_FALL_LO, SRC_FALL_HI
  } asac_src_t;
  typedef enum logic [1:0] {OBJ_LPOS, OBJ_RPOS, OBJ_SPEED, OBJ_TIMER}
    asac_obj_t;
  typedef enum logic [1:0] {CND_GE, CND_GT, CND_EQ, CND_LT} asac_cnd_t;
  typedef enum logic [2:0] {
    ACT_NONE, ACT_LD_LPOS, ACT_LD_RPOS, ACT_SV_LPOS, ACT_SV_RPOS,
    ACT_SV_SPEED, ACT_SV_TIMER
  } asac_act_t;
  typedef struct packed {
    asac_act_t act;
    asac_cnd_t cond;
    asac_obj_t obj;
    logic [1:0] pin;
    asac_src_t src;
  } asac_scfg_t;
endpackage : asac_pkg

// File: core/asac_split.sv
// split pulse generator driven by drive pulses
`timescale 1ns/10ps
`default_nettype none
module asac_split (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        go,
  input  wire logic        halt,
  input  wire logic        step,
  input  wire logic [15:0] len,
  input  wire logic [15:0] width,
  input  wire logic [15:0] count,
  input  wire logic        inf,
  // results
  output logic             out,
  output logic             busy,
  output logic             go_p,
  output logic             end_p,
  output logic             pulse_p
);
  logic [15:0] pos_reg;
  logic [15:0] done_reg;
  wire last_pos = (pos_reg == len - 16'h0001);
  wire last_one = !inf && (done_reg + 16'h0001 == count);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_reg  <= '0;
      done_reg <= '0;
      out      <= 1'b0;
      busy     <= 1'b0;
      go_p     <= 1'b0;
      end_p    <= 1'b0;
      pulse_p  <= 1'b0;
    end else begin
      go_p    <= go && !busy;
      end_p   <= busy && (halt || (step && last_pos && last_one));
      pulse_p <= (go && !busy) || (busy && !halt && step && last_pos
                 && !last_one);
      if (go && !busy) begin
        busy     <= 1'b1;
        out      <= 1'b1;
        pos_reg  <= '0;
        done_reg <= '0;
      end else if (busy && (halt || (step && last_pos && last_one))) begin
        busy <= 1'b0; // [RULE8]
        out  <= 1'b0;
      end else if (busy && step && last_pos) begin
        pos_reg  <= '0;
        done_reg <= done_reg + 16'h0001;
        out      <= 1'b1;
      end else if (busy && step) begin
        pos_reg <= pos_reg + 16'h0001;
        out     <= (pos_reg + 16'h0001 < width); // [RULE7]
      end
    end
  end
endmodule : asac_split
`default_nettype wire

// File: core/asac_top.sv
// axis position counters, compare registers and sync action triggers
// Function
// [RULE1] logical and real position counters are signed 32-bit pulse counts.
// [RULE2] each counter wraps as a ring at a software-set maximum value.
// [RULE3] software limits span +/-2147483647 and stop the drive when passed; the code only raises LIMIT_PLUS at lpos >= slp_reg, LIMIT_MINUS below slm_reg.
// [RULE4] four 32-bit general registers serve as compare, load and save.
// [RULE5] each general register is compared with a selected live value.
// [RULE6] sets load position from a register or save live values into it.
// [RULE7] split length is 2..65535 pulses and split width 1..65534 pulses.
// [RULE8] split pulse count is 1..65535, or endless until stopped.
// [RULE9] four sync sets each fire when their register compare changes; the code fires only when the compare becomes true.
// [RULE10] operand is lpos, rpos, speed or timer; test is >=, >, = or <.
// [RULE11] drive start/end and constant-speed entry/exit fire a set.
// [RULE12] split start, split end and each split pulse fire a set.
// [RULE13] io pin m edges, alone or qualified by pin m+4 level, fire a set.
// [RULE14] timer expiry and a software command also fire a set.
// [RULE15] compare change fires once per transition, checked every cycle; the code fires only on false-to-true transitions.
`timescale 1ns/10ps
`default_nettype none
module asac_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // drive engine
  input  wire logic        DRV_STEP,
  input  wire logic        DRV_DIR,
  input  wire logic        ENC_STEP,
  input  wire logic        ENC_DIR,
  input  wire logic        DRV_BUSY,
  input  wire logic        DRV_CONST,
  input  wire logic [31:0] DRV_SPEED,
  input  wire logic [31:0] TMR_VAL,
  input  wire logic        TMR_UP,
  // pins
  input  wire logic [7:0]  AXIS_GENERAL_IO_PIN,
  // results
  output logic      [3:0]  SYNC_FIRE,
  output logic             SPLIT_OUT,
  output logic             LIMIT_PLUS,
  output logic             LIMIT_MINUS,
  output logic             IRQ
);
  localparam int N = asac_pkg::SET_N;
  localparam int P = asac_pkg::PIO_N;

  logic [31:0] lpos_reg, rpos_reg, lring_reg, rring_reg;
  logic [31:0] lpos_next, rpos_next;
  logic [31:0] slp_reg, slm_reg, splen_reg;
  logic [16:0] spcnt_reg;
  logic [asac_pkg::ST_W-1:0] stat_reg, mask_reg, stat_next;
  logic [1:0]  limen_reg;
  logic [31:0] mr_reg [N];
  logic [31:0] mr_next [N];
  asac_pkg::asac_scfg_t scfg_reg [N];
  logic [7:0]  addr_reg;
  logic        wr_reg;
  logic [31:0] hrdata_reg, rdata;
  logic [N-1:0] cmp_res, cmp_prev_reg, cmp_evt, src_evt, fire, cmd_act;
  logic [N-1:0] ld_l, ld_r, sv;
  logic [31:0] sv_val [N];
  logic [P-1:0] s1_reg, s2_reg, s3_reg, pio_stb_reg, pio_prev_reg;
  logic [P-1:0] pio_rise, pio_fall;
  logic        busy_prev_reg, const_prev_reg;
  logic        sp_busy, sp_go, sp_end, sp_pulse;

  // bus decode; zero wait states so the slave never stalls
  wire take = HSEL && HTRANS[1] && HREADY;
  wire [7:0] raddr = HADDR[7:0];
  wire w_lpos  = wr_reg && addr_reg == asac_pkg::A_LPOS;
  wire w_rpos  = wr_reg && addr_reg == asac_pkg::A_RPOS;
  wire w_lring = wr_reg && addr_reg == asac_pkg::A_LRING;
  wire w_rring = wr_reg && addr_reg == asac_pkg::A_RRING;
  wire w_slp   = wr_reg && addr_reg == asac_pkg::A_SLP;
  wire w_slm   = wr_reg && addr_reg == asac_pkg::A_SLM;
  wire w_splen = wr_reg && addr_reg == asac_pkg::A_SPLEN;
  wire w_spcnt = wr_reg && addr_reg == asac_pkg::A_SPCNT;
  wire w_cmd   = wr_reg && addr_reg == asac_pkg::A_CMD;
  wire w_stat  = wr_reg && addr_reg == asac_pkg::A_STAT;
  wire w_mask  = wr_reg && addr_reg == asac_pkg::A_MASK;
  wire w_limen = wr_reg && addr_reg == asac_pkg::A_LIMEN;
  wire [1:0] widx = addr_reg[3:2];
  wire w_mrs = wr_reg && addr_reg[7:4] == asac_pkg::A_MR0[7:4]
               && addr_reg[1:0] == 2'h0;
  wire w_scs = wr_reg && addr_reg[7:4] == asac_pkg::A_SC0[7:4]
               && addr_reg[1:0] == 2'h0;
  wire [31:0] sl_wd = (HWDATA == asac_pkg::SL_BAD) ? asac_pkg::SL_MIN
                      : HWDATA; // [RULE3]
  wire [15:0] len_wd = (HWDATA[15:0] < asac_pkg::SPL_MIN) ?
                       asac_pkg::SPL_MIN : HWDATA[15:0]; // [RULE7]
  wire [15:0] wid_wd = (HWDATA[31:16] < asac_pkg::SPW_MIN) ?
                       asac_pkg::SPW_MIN : (HWDATA[31:16] >
                       asac_pkg::SPW_MAX) ? asac_pkg::SPW_MAX
                       : HWDATA[31:16]; // [RULE7]
  wire [15:0] cnt_wd = (HWDATA[15:0] < asac_pkg::SPN_MIN) ?
                       asac_pkg::SPN_MIN : HWDATA[15:0]; // [RULE8]
  assign cmd_act = w_cmd ? HWDATA[asac_pkg::CMD_ACT_LSB +: N] : '0;

  assign HRDATA    = hrdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign IRQ       = |(stat_reg & mask_reg);

  always_comb begin
    rdata = '0;
    case (raddr)
      asac_pkg::A_LPOS:  rdata = lpos_reg;
      asac_pkg::A_RPOS:  rdata = rpos_reg;
      asac_pkg::A_LRING: rdata = lring_reg;
      asac_pkg::A_RRING: rdata = rring_reg;
      asac_pkg::A_SLP:   rdata = slp_reg;
      asac_pkg::A_SLM:   rdata = slm_reg;
      asac_pkg::A_SPLEN: rdata = splen_reg;
      asac_pkg::A_SPCNT: rdata = {15'h0000, spcnt_reg};
      asac_pkg::A_CMD:   rdata = {31'h0000_0000, sp_busy};
      asac_pkg::A_STAT:  rdata = {26'h000_0000, stat_reg};
      asac_pkg::A_MASK:  rdata = {26'h000_0000, mask_reg};
      asac_pkg::A_LIMEN: rdata = {30'h0000_0000, limen_reg};
      default: begin
        if (raddr[7:4] == asac_pkg::A_MR0[7:4] && raddr[1:0] == 2'h0)
          rdata = mr_reg[raddr[3:2]];
        else if (raddr[7:4] == asac_pkg::A_SC0[7:4] && raddr[1:0] == 2'h0)
          rdata = {19'h0_0000, scfg_reg[raddr[3:2]]};
      end
    endcase
  end

  // ring stepping: max of all ones gives the plain two's complement wrap
  function automatic logic [31:0] ring(input logic [31:0] cur,
                                       input logic [31:0] top,
                                       input logic up);
    if (up) ring = (cur == top) ? 32'h0000_0000 : cur + 32'h0000_0001;
    else    ring = (cur == 32'h0000_0000) ? top : cur - 32'h0000_0001;
  endfunction : ring

  // a load by a sync set beats a bus write, which beats counting
  always_comb begin
    lpos_next = lpos_reg;
    rpos_next = rpos_reg;
    if (DRV_STEP) lpos_next = ring(lpos_reg, lring_reg, DRV_DIR); // [RULE2]
    if (ENC_STEP) rpos_next = ring(rpos_reg, rring_reg, ENC_DIR); // [RULE2]
    if (w_lpos) lpos_next = HWDATA;
    if (w_rpos) rpos_next = HWDATA;
    for (int k = N - 1; k >= 0; k--) begin
      if (ld_l[k]) lpos_next = mr_reg[k]; // [RULE6]
      if (ld_r[k]) rpos_next = mr_reg[k]; // [RULE6]
    end
  end

  // sticky events: set wins over a write-one clear in the same cycle
  assign stat_next = (stat_reg & ~(w_stat ? HWDATA[asac_pkg::ST_W-1:0]
                     : '0)) | {LIMIT_MINUS, LIMIT_PLUS, fire};

  // three-stage pin sampling, accepted once stages two and three agree
  genvar b;
  for (b = 0; b < P; b++) begin : g_pin
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        s1_reg[b]      <= 1'b0;
        s2_reg[b]      <= 1'b0;
        s3_reg[b]      <= 1'b0;
        pio_stb_reg[b] <= 1'b0;
      end else begin
        s1_reg[b] <= AXIS_GENERAL_IO_PIN[b];
        s2_reg[b] <= s1_reg[b];
        s3_reg[b] <= s2_reg[b];
        if (s2_reg[b] == s3_reg[b]) pio_stb_reg[b] <= s3_reg[b];
      end
    end
    assign pio_rise[b] = pio_stb_reg[b] && !pio_prev_reg[b];
    assign pio_fall[b] = !pio_stb_reg[b] && pio_prev_reg[b];
  end

  genvar k;
  for (k = 0; k < N; k++) begin : g_set
    asac_pkg::asac_scfg_t c;
    logic [31:0] opd;
    logic        pr, pf, ql;
    assign c = scfg_reg[k];
    assign opd = (c.obj == asac_pkg::OBJ_LPOS)  ? lpos_reg :
                 (c.obj == asac_pkg::OBJ_RPOS)  ? rpos_reg :
                 (c.obj == asac_pkg::OBJ_SPEED) ? DRV_SPEED
                 : TMR_VAL; // [RULE5]
    always_comb begin
      case (c.cond)
        asac_pkg::CND_GE: cmp_res[k] = $signed(opd) >= $signed(mr_reg[k]);
        asac_pkg::CND_GT: cmp_res[k] = $signed(opd) > $signed(mr_reg[k]);
        asac_pkg::CND_EQ: cmp_res[k] = opd == mr_reg[k];
        default:          cmp_res[k] = $signed(opd) < $signed(mr_reg[k]);
      endcase // [RULE10]
    end
    assign cmp_evt[k] = cmp_res[k] && !cmp_prev_reg[k]; // [RULE15]
    assign pr = pio_rise[c.pin];
    assign pf = pio_fall[c.pin];
    assign ql = pio_stb_reg[{1'b1, c.pin}];
    always_comb begin
      case (c.src)
        asac_pkg::SRC_CMP:      src_evt[k] = cmp_evt[k]; // [RULE9]
        asac_pkg::SRC_DRV_GO:   src_evt[k] = DRV_BUSY && !busy_prev_reg;
        asac_pkg::SRC_DRV_END:  src_evt[k] = !DRV_BUSY && busy_prev_reg;
        asac_pkg::SRC_CV_IN:    src_evt[k] = DRV_CONST && !const_prev_reg;
        asac_pkg::SRC_CV_OUT:   src_evt[k] = !DRV_CONST && const_prev_reg;
        asac_pkg::SRC_SP_GO:    src_evt[k] = sp_go; // [RULE12]
        asac_pkg::SRC_SP_END:   src_evt[k] = sp_end; // [RULE12]
        asac_pkg::SRC_SP_PULSE: src_evt[k] = sp_pulse; // [RULE12]
        asac_pkg::SRC_TMR_UP:   src_evt[k] = TMR_UP; // [RULE14]
        asac_pkg::SRC_PIO_RISE: src_evt[k] = pr; // [RULE13]
        asac_pkg::SRC_PIO_FALL: src_evt[k] = pf; // [RULE13]
        asac_pkg::SRC_RISE_LO:  src_evt[k] = pr && !ql; // [RULE13]
        asac_pkg::SRC_RISE_HI:  src_evt[k] = pr && ql; // [RULE13]
        asac_pkg::SRC_FALL_LO:  src_evt[k] = pf && !ql; // [RULE13]
        asac_pkg::SRC_FALL_HI:  src_evt[k] = pf && ql; // [RULE13]
        default:                src_evt[k] = 1'b0;
      endcase // [RULE11]
    end
    assign fire[k] = src_evt[k] || cmd_act[k]; // [RULE14]
    assign ld_l[k] = fire[k] && c.act == asac_pkg::ACT_LD_LPOS;
    assign ld_r[k] = fire[k] && c.act == asac_pkg::ACT_LD_RPOS;
    assign sv[k] = fire[k] && (c.act == asac_pkg::ACT_SV_LPOS
                   || c.act == asac_pkg::ACT_SV_RPOS
                   || c.act == asac_pkg::ACT_SV_SPEED
                   || c.act == asac_pkg::ACT_SV_TIMER);
    assign sv_val[k] = (c.act == asac_pkg::ACT_SV_LPOS) ? lpos_reg :
                       (c.act == asac_pkg::ACT_SV_RPOS) ? rpos_reg :
                       (c.act == asac_pkg::ACT_SV_SPEED) ? DRV_SPEED
                       : TMR_VAL; // [RULE6]
    assign mr_next[k] = sv[k] ? sv_val[k] : (w_mrs && widx == 2'(k)) ?
                        HWDATA : mr_reg[k]; // [RULE4]
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        mr_reg[k]   <= '0;
        scfg_reg[k] <= '0;
      end else begin
        mr_reg[k] <= mr_next[k];
        if (w_scs && widx == 2'(k))
          scfg_reg[k] <= asac_pkg::asac_scfg_t'(HWDATA[asac_pkg::SCFG_W-1:0]);
      end
    end
  end

  asac_split u_split (
    .clk     (CLK),
    .rst_n   (RST_N),
    .go      (w_cmd && HWDATA[asac_pkg::CMD_SP_GO]),
    .halt    (w_cmd && HWDATA[asac_pkg::CMD_SP_STOP]),
    .step    (DRV_STEP),
    .len     (splen_reg[15:0]),
    .width   (splen_reg[31:16]),
    .count   (spcnt_reg[15:0]),
    .inf     (spcnt_reg[asac_pkg::SPCNT_INF]), // [RULE8]
    .out     (SPLIT_OUT),
    .busy    (sp_busy),
    .go_p    (sp_go),
    .end_p   (sp_end),
    .pulse_p (sp_pulse)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      addr_reg   <= '0;
      wr_reg     <= 1'b0;
      hrdata_reg <= '0;
    end else begin
      wr_reg <= take && HWRITE;
      if (take) addr_reg <= raddr;
      if (take && !HWRITE) hrdata_reg <= rdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lpos_reg <= '0;
      rpos_reg <= '0;
    end else begin
      lpos_reg <= lpos_next; // [RULE1]
      rpos_reg <= rpos_next; // [RULE1]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lring_reg <= asac_pkg::RING_RST;
      rring_reg <= asac_pkg::RING_RST;
      slp_reg   <= asac_pkg::SLP_RST;
      slm_reg   <= asac_pkg::SL_MIN;
      limen_reg <= '0;
      splen_reg <= {asac_pkg::SPW_MIN, asac_pkg::SPL_MIN};
      spcnt_reg <= {1'b0, asac_pkg::SPN_MIN};
      mask_reg  <= '0;
    end else begin
      if (w_lring) lring_reg <= HWDATA;
      if (w_rring) rring_reg <= HWDATA;
      if (w_slp)   slp_reg   <= sl_wd;
      if (w_slm)   slm_reg   <= sl_wd;
      if (w_limen) limen_reg <= HWDATA[1:0];
      if (w_splen) splen_reg <= {wid_wd, len_wd};
      if (w_spcnt) spcnt_reg <= {HWDATA[asac_pkg::SPCNT_INF], cnt_wd};
      if (w_mask)  mask_reg  <= HWDATA[asac_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stat_reg       <= '0;
      cmp_prev_reg   <= '0;
      pio_prev_reg   <= '0;
      busy_prev_reg  <= 1'b0;
      const_prev_reg <= 1'b0;
      SYNC_FIRE      <= '0;
      LIMIT_PLUS     <= 1'b0;
      LIMIT_MINUS    <= 1'b0;
    end else begin
      stat_reg       <= stat_next;
      cmp_prev_reg   <= cmp_res; // [RULE15]
      pio_prev_reg   <= pio_stb_reg;
      busy_prev_reg  <= DRV_BUSY; // [RULE11]
      const_prev_reg <= DRV_CONST; // [RULE11]
      SYNC_FIRE      <= fire;
      LIMIT_PLUS  <= limen_reg[0]
                     && $signed(lpos_reg) >= $signed(slp_reg); // [RULE3]
      LIMIT_MINUS <= limen_reg[1]
                     && $signed(lpos_reg) < $signed(slm_reg); // [RULE3]
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire quiet_l = !w_lpos && !(|ld_l);
  sequence s_cmd0;
    w_cmd && HWDATA[asac_pkg::CMD_ACT_LSB];
  endsequence
  sequence s_fire_seen;
    SYNC_FIRE[0] ##1 stat_reg[0];
  endsequence
  lpos_up_a: assert property (DRV_STEP && DRV_DIR && quiet_l // [RULE1]
    && lpos_reg != lring_reg |=> lpos_reg == $past(lpos_reg) + 32'h1)
    else $error("lpos did not count up");
  ring_wrap_a: assert property (DRV_STEP && DRV_DIR && quiet_l // [RULE2]
    && lpos_reg == lring_reg |=> lpos_reg == 32'h0)
    else $error("lpos did not wrap at ring top");
  limit_plus_a: assert property (limen_reg[0] && // [RULE3]
    $signed(lpos_reg) >= $signed(slp_reg) |=> LIMIT_PLUS)
    else $error("plus limit not raised");
  slm_clamp_a: assert property (w_slm && HWDATA == asac_pkg::SL_BAD // [RULE3]
    |=> slm_reg == asac_pkg::SL_MIN)
    else $error("minus limit not clamped");
  save_timer_a: assert property (fire[0] && // [RULE6]
    scfg_reg[0].act == asac_pkg::ACT_SV_TIMER
    |=> mr_reg[0] == $past(TMR_VAL))
    else $error("timer not saved");
  cmp_eq_a: assert property (scfg_reg[0].cond == asac_pkg::CND_EQ // [RULE10]
    && scfg_reg[0].obj == asac_pkg::OBJ_LPOS && lpos_reg == mr_reg[0]
    |-> cmp_res[0])
    else $error("equal compare missed");
  cmp_once_a: assert property (cmp_evt[0] |=> !cmp_evt[0]) // [RULE15]
    else $error("compare change fired twice");
  cmd_fire_a: assert property (s_cmd0 |=> s_fire_seen) // [RULE14]
    else $error("command did not fire set 0");
  irq_raise_a: assert property (fire[0] && mask_reg[0] && !w_mask // [RULE14]
    |=> IRQ)
    else $error("interrupt not raised");
endmodule : asac_top
`default_nettype wire

// File: dv/tb.sv
// self-checking bench of the axis sync action block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        hsel     = 1'b0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] spd      = 32'h0;
  logic [31:0] tmr      = 32'h0;
  logic [1:0]  stp      = 2'h0;
  logic        dir      = 1'b1;
  logic        busy     = 1'b0;
  logic        cst      = 1'b0;
  logic        tup      = 1'b0;
  logic [7:0]  pio      = 8'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [3:0]  fire;
  logic        sp_out;
  logic        lim_p;
  logic        lim_m;
  logic        irq;
  int          errors   = 0;
  int          n_checks = 0;
  int          fires[4] = '{0, 0, 0, 0};
  int          pos[2]   = '{0, 0};
  int          ring[2]  = '{-1, -1};
  int          fo[4]    = '{-1, 0, -1, 0};
  int          tv[4]    = '{0, 1, 0, -1};

  always #2 clk = ~clk;

  asac_top i_dut (
    .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .DRV_STEP(stp[0]), .DRV_DIR(dir), .ENC_STEP(stp[1]), .ENC_DIR(dir),
    .DRV_BUSY(busy), .DRV_CONST(cst), .DRV_SPEED(spd), .TMR_VAL(tmr),
    .TMR_UP(tup), .AXIS_GENERAL_IO_PIN(pio), .SYNC_FIRE(fire),
    .SPLIT_OUT(sp_out), .LIMIT_PLUS(lim_p), .LIMIT_MINUS(lim_m), .IRQ(irq)
  );

  // nba keeps the count stable for readers woken by the same edge
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (fire[k] === 1'b1) begin
        fires[k] <= fires[k] + 1;
      end
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // master waits on hready, zero wait states are not assumed
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask : rdc

  task automatic step(input int c, input logic up);
    @(posedge clk);
    stp <= 2'(1 << c);
    dir <= up;
    @(posedge clk);
    stp <= 2'h0;
    if (up) pos[c] = (pos[c] == ring[c]) ? 0 : pos[c] + 1;
    else pos[c] = (pos[c] == 0) ? ring[c] : pos[c] - 1;
  endtask : step

  task automatic setv(input int o, input int v);
    if (o < 2) begin
      wr(o == 0 ? asac_pkg::A_LPOS : asac_pkg::A_RPOS, v);
      pos[o] = v;
    end else if (o == 2) spd <= 32'(v);
    else tmr <= 32'(v);
  endtask : setv

  // pre-level first so only the wanted edge lands on the watched pin
  task automatic pe(input logic rs, input logic q);
    pio[5] <= q;
    pio[1] <= ~rs;
    cyc(8);
    pio[1] <= rs;
    cyc(8);
  endtask : pe

  function automatic logic [31:0] cw(input int a, input int c,
                                     input int o, input int s);
    asac_pkg::asac_scfg_t f;
    f.act = asac_pkg::asac_act_t'(a);
    f.cond = asac_pkg::asac_cnd_t'(c);
    f.obj = asac_pkg::asac_obj_t'(o);
    f.pin = 2'h1;
    f.src = asac_pkg::asac_src_t'(s);
    return {19'h0, f};
  endfunction : cw

  initial begin
    cyc(20000);
    errors++;
    results();
  end

  initial begin
    logic [7:0]  ra[7];
    logic [31:0] re[7];
    logic [31:0] ev[4];
    logic [31:0] r;
    int          b;
    logic        rs;
    void'($urandom(54206));
    ra = '{asac_pkg::A_LPOS, asac_pkg::A_RRING, asac_pkg::A_SLP,
           asac_pkg::A_SLM, asac_pkg::A_SPCNT, asac_pkg::A_STAT, 8'hfc};
    re = '{32'h0, asac_pkg::RING_RST, asac_pkg::SLP_RST,
           asac_pkg::SL_MIN, 32'h1, 32'h0, 32'h0};
    cyc(5);
    rst_n <= 1'b1;
    chk("outs", 32'h0, 32'({irq, fire, sp_out, lim_p, lim_m, hresp}));
    for (int i = 0; i < 7; i++) rdc("reset", ra[i], re[i]);
    r = $urandom();
    wr(asac_pkg::A_LPOS, r);
    pos[0] = r;
    for (int i = 0; i < 12; i++) step(i % 2, 1'($urandom()));
    rdc("lpos", asac_pkg::A_LPOS, pos[0]);
    setv(1, 32'h7fff_ffff);
    step(1, 1'b1);
    rdc("rpos", asac_pkg::A_RPOS, pos[1]);
    wr(asac_pkg::A_LRING, 32'h5);
    setv(0, 5);
    ring[0] = 5;
    step(0, 1'b1);
    rdc("ring_up", asac_pkg::A_LPOS, pos[0]);
    step(0, 1'b0);
    rdc("ring_dn", asac_pkg::A_LPOS, pos[0]);
    done("counters");
    wr(asac_pkg::A_SLP, asac_pkg::SL_BAD);
    rdc("slp_clamp", asac_pkg::A_SLP, asac_pkg::SL_MIN);
    wr(asac_pkg::A_SLP, 32'ha);
    wr(asac_pkg::A_SLM, 32'h8);
    setv(0, 9);
    wr(asac_pkg::A_LIMEN, 32'h3);
    cyc(2);
    chk("lim", 32'h0, 32'({lim_p, lim_m}));
    step(0, 1'b1);
    cyc(2);
    chk("lim", 32'h2, 32'({lim_p, lim_m}));
    repeat (3) step(0, 1'b0);
    cyc(2);
    chk("lim", 32'h1, 32'({lim_p, lim_m}));
    wr(asac_pkg::A_LIMEN, 32'h0);
    rdc("stat_lim", asac_pkg::A_STAT, 32'h30);
    done("limits");
    for (int o = 0; o < 4; o++) begin
      r = $urandom_range(1000, 100);
      wr(asac_pkg::A_MR0 + 8'(4 * o), r);
      rdc("mr", asac_pkg::A_MR0 + 8'(4 * o), r);
      setv(o, r + fo[o]);
      wr(asac_pkg::A_SC0 + 8'(4 * o), cw(0, o, o, 1));
      cyc(4);
      b = fires[o];
      setv(o, r + tv[o]);
      cyc(12);
      chk("cmp_fire", 32'h1, 32'(fires[o] - b));
      setv(o, r + fo[o]);
      cyc(12);
      chk("cmp_once", 32'h1, 32'(fires[o] - b));
    end
    done("compare");
    for (int s = 2; s < 16; s++) begin
      if (s > 5 && s < 9) continue;
      wr(asac_pkg::A_SC0, cw(0, 0, 0, s));
      rs = (s == 10) || (s == 12) || (s == 13);
      cyc(4);
      b = fires[0];
      if (s > 11) begin
        pe(rs, ~s[0]);
        chk("pin_qual", 32'h0, 32'(fires[0] - b));
      end
      case (s)
        2, 3: busy <= (s == 2);
        4, 5: cst <= (s == 4);
        9: tup <= 1'b1;
        default: pe(rs, s[0]);
      endcase
      cyc(1);
      tup <= 1'b0;
      cyc(10);
      chk("src_fire", 32'h1, 32'(fires[0] - b));
    end
    done("sources");
    wr(asac_pkg::A_STAT, 32'h3f);
    wr(asac_pkg::A_MASK, 32'h1);
    cyc(1);
    chk("irq", 32'h0, 32'(irq));
    for (int k = 0; k < 4; k++) begin
      b = fires[k];
      wr(asac_pkg::A_CMD, 32'h10 << k);
      cyc(3);
      chk("cmd_fire", 32'h1, 32'(fires[k] - b));
    end
    chk("irq", 32'h1, 32'(irq));
    rdc("stat", asac_pkg::A_STAT, 32'hf);
    wr(asac_pkg::A_STAT, 32'h1);
    cyc(1);
    chk("irq", 32'h0, 32'(irq));
    rdc("stat", asac_pkg::A_STAT, 32'he);
    done("irq");
    ev = '{pos[0], pos[1], spd, tmr};
    for (int a = 1; a < 7; a++) begin
      r = $urandom();
      if (a < 3) wr(asac_pkg::A_MR0 + 8'hc, r);
      wr(asac_pkg::A_SC0 + 8'hc, cw(a, 0, 0, 0));
      wr(asac_pkg::A_CMD, 32'h80);
      cyc(2);
      if (a < 3) pos[a - 1] = r;
      if (a < 3) ev[a - 1] = r;
      if (a < 3) rdc("load", 8'(4 * a - 4), r);
      else rdc("save", asac_pkg::A_MR0 + 8'hc, ev[a - 3]);
    end
    done("actions");
    wr(asac_pkg::A_SPLEN, 32'h0);
    rdc("splen", asac_pkg::A_SPLEN,
        {asac_pkg::SPW_MIN, asac_pkg::SPL_MIN});
    wr(asac_pkg::A_SPCNT, 32'h0);
    rdc("spcnt", asac_pkg::A_SPCNT, 32'h1);
    wr(asac_pkg::A_SPLEN, 32'h0001_0003);
    wr(asac_pkg::A_SPCNT, 32'h2);
    for (int k = 0; k < 3; k++) begin
      wr(asac_pkg::A_SC0 + 8'(4 * k), cw(0, 0, 0, 6 + k));
      ev[k] = fires[k];
    end
    wr(asac_pkg::A_CMD, 32'h1);
    cyc(2);
    chk("split_out", 32'h1, 32'(sp_out));
    for (int i = 1; i < 7; i++) begin
      step(0, 1'b1);
      cyc(2);
      chk("split_out", 32'(i == 3), 32'(sp_out));
    end
    rdc("split_busy", asac_pkg::A_CMD, 32'h0);
    for (int k = 0; k < 3; k++) begin
      chk("split_fire", 32'(k / 2 + 1), 32'(fires[k] - ev[k]));
    end
    wr(asac_pkg::A_SPCNT, 32'h1_0001);
    wr(asac_pkg::A_CMD, 32'h1);
    repeat (8) step(0, 1'b1);
    rdc("split_inf", asac_pkg::A_CMD, 32'h1);
    wr(asac_pkg::A_CMD, 32'h2);
    cyc(2);
    rdc("split_stop", asac_pkg::A_CMD, 32'h0);
    rdc("lpos", asac_pkg::A_LPOS, pos[0]);
    done("split");
    results();
  end
endmodule : tb
`default_nettype wire
